// ---- include/mcs_pkg.sv ----
`default_nettype none
package mcs_pkg;
   // ************************************************************
   // register byte addresses (own choice, one word each)
   // ************************************************************
   localparam logic [11:0] OFF_PRI_LOCK  = 12'h000;
   localparam logic [11:0] OFF_SEC_LOCK  = 12'h004;
   localparam logic [11:0] OFF_TEST_PORT = 12'h008;
   localparam logic [11:0] OFF_PAGE      = 12'h00C;
   localparam logic [11:0] OFF_PWR_A     = 12'h010;
   localparam logic [11:0] OFF_PWR_B     = 12'h014;
   localparam logic [11:0] OFF_SPACE_MAP = 12'h018;
   localparam logic [11:0] OFF_MEM_A     = 12'h01C;
   localparam logic [11:0] OFF_MEM_B     = 12'h020;

   // ************************************************************
   // writable-bit masks and reset values
   // ************************************************************
   localparam logic [7:0] MASK_TEST_PORT = 8'h01;
   localparam logic [7:0] MASK_PWR_A     = 8'h3A;
   localparam logic [7:0] MASK_PWR_B     = 8'h7D;
   localparam logic [7:0] MASK_SPACE_MAP = 8'h9F;
   localparam logic [7:0] MASK_SEC_LOCK  = 8'h8F;
   localparam logic [7:0] MASK_MEM_B     = 8'h3F;
   localparam logic [7:0] RST_PAGE       = 8'h00;
   localparam logic [7:0] RST_TEST_PORT  = 8'h00;
   localparam logic [7:0] RST_PWR        = 8'h00;
   localparam logic [7:0] SPACE_MAP_KEEP = 8'h1E;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BIT_TEST_ON    = 0;
   localparam int BIT_APD        = 1;
   localparam int BIT_TURBO_OFF  = 3;
   localparam int BIT_ARRAY_CLK  = 4;
   localparam int BIT_MCELL_CLK  = 5;
   localparam int BIT_ADDR_BLOCK = 0;
   localparam int BIT_CONTROL_INPUT_0_OFF  = 2;
   localparam int BIT_FETCH_SRAM = 0;
   localparam int BIT_FETCH_SEC  = 1;
   localparam int BIT_FETCH_PRI  = 2;
   localparam int BIT_READ_SEC   = 3;
   localparam int BIT_READ_PRI   = 4;
   localparam int BIT_PERIPH     = 7;

   // ************************************************************
   // memory organisation
   // ************************************************************
   localparam int PRI_SECTORS   = 8;
   localparam int SEC_SECTORS   = 4;
   localparam int PRI_SECTOR_KB = 64;
   localparam int SEC_SECTOR_KB = 8;

   // power gating outputs grouped for the logic array
   typedef struct packed {
      logic       auto_power_down;
      logic       turbo_off;
      logic       array_clk_gate;
      logic       mcell_clk_gate;
      logic [7:0] array_addr;
      logic [2:0] control_in;
      logic       ale_in;
      logic       high_byte_write_strobe;
   } mcs_gate_t;
endpackage
`default_nettype wire

// ---- logic/mcs_regs.sv ----
// Operation
// - primary lock status bits 7..0, one per sector, 1 means protected.
// - secondary lock status bits 3..0, four sectors, 1 means protected.
// - secondary lock bit 7 shows security flag; bits 6..4 unused.
// - test port bit 0 turns the serial test port on.
// - eight-bit page register drives array page inputs, resets to zero.
// - power gating A clears only at power-up, not on later resets.
// - power gating A bit 1 enables automatic power-down.
// - power gating A bit 3 set turns turbo off.
// - bit 4 gates clock to AND array; clock change wakes array without turbo.
// - power gating A bit 5 disconnects clock from macrocells.
// - power gating B bit 0 blocks address lines A7-A0 from array.
// - in 16-bit mode array address comes from port F low and bus upper.
// - power gating B bits 2..6 disconnect control 0..2, latch strobe, high write.
// - space mapping bits 1..4 load user defaults on reset; 0 and 7 cleared.
// - space mapping bits 0..4 act only in 16-bit alternate bus mode.
// - fetch strobe allows per memory, read strobe allows for flash only, from space mapping.
// - space mapping bit 7 enables port F peripheral mode.
// - memory size A low nibble gives primary flash size code.
// - memory size A high nibble gives SRAM size code.
// - memory size B gives secondary size, type; bits 7..6 zero.
// - decode makes eight primary, four secondary selects, one SRAM select.
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module mcs_regs #(
   parameter logic [7:0] SPACE_MAP_DEFAULT = 8'h1E,   // user-configured map bits 4..1
   parameter logic [3:0] PRI_SIZE_CODE     = 4'h4,    // 4 Mbit primary flash
   parameter logic [3:0] SRAM_SIZE_CODE    = 4'h3,    // 64 Kbit sram
   parameter logic [3:0] SEC_SIZE_CODE     = 4'h2,    // 256 Kbit secondary
   parameter logic [1:0] SEC_TYPE_CODE     = 2'h0     // flash
) (
   input  wire logic                 pclk,              // bus clock, 100 MHz
   input  wire logic                 presetn,           // async reset, active low
   input  wire logic                 power_on_rst_n,    // power-up reset, active low
   input  wire logic                 psel,              // apb select
   input  wire logic                 penable,           // apb access phase
   input  wire logic                 pwrite,            // apb write
   input  wire logic [11:0]          paddr,             // apb byte address
   input  wire logic [31:0]          pwdata,            // apb write data
   output logic      [31:0]          prdata,            // apb read data
   output logic                      pready,            // apb ready
   output logic                      pslverr,           // apb error, unmapped
   input  wire logic [7:0]           primary_lock_in,   // flash sector protect state
   input  wire logic [3:0]           secondary_lock_in, // boot sector protect state
   input  wire logic                 security_set_in,   // security flag state
   input  wire logic                 alt_bus_mode,      // 16-bit alternate bus mode
   input  wire logic                 external_clock_input, // array clock pin
   input  wire logic [7:0]           addr_low_in,       // address lines A7-A0
   input  wire logic [3:0]           port_f_low_pins,   // alternate A3-A0
   input  wire logic [3:0]           mux_bus_upper_lines, // alternate A7-A4
   input  wire logic [2:0]           control_inputs,    // control inputs 0..2
   input  wire logic                 ale_in,            // address latch strobe
   input  wire logic                 high_byte_write_strobe, // high byte write
   input  wire logic [2:0]           region_hit,        // decoded: pri, sec, sram
   input  wire logic [2:0]           sector_index,      // sector from address
   input  wire logic                 program_fetch_strobe, // fetch cycle active
   input  wire logic                 read_strobe,       // data read active
   output logic                      test_port_on,      // serial test port enable
   output logic      [7:0]           page_bits,         // page inputs to array
   output mcs_pkg::mcs_gate_t        gate_out,          // power gated array inputs
   output logic                      array_wake,        // clock change wake pulse
   output logic                      port_f_periph_mode, // port F peripheral mode
   output logic      [7:0]           primary_sector_selects,   // 64 Kbyte sectors
   output logic      [3:0]           secondary_sector_selects, // 8 Kbyte sectors
   output logic                      sram_select        // sram select
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [7:0]  lock_p_m, lock_p_s;
   logic [4:0]  lock_s_m, lock_s_s;
   logic [1:0]  clk_m;
   logic        clk_s, clk_prev_q;

   // two stages on every pin-sourced status bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_p_m <= 8'h00;
         lock_p_s <= 8'h00;
         lock_s_m <= 5'h00;
         lock_s_s <= 5'h00;
      end else begin
         lock_p_m <= primary_lock_in;
         lock_p_s <= lock_p_m;
         lock_s_m <= {security_set_in, secondary_lock_in};
         lock_s_s <= lock_s_m;
      end
   end

   // clock pin is sampled, edge found only past third stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_m      <= 2'h0;
         clk_s      <= 1'b0;
         clk_prev_q <= 1'b0;
      end else begin
         clk_m      <= {clk_m[0], external_clock_input};
         clk_s      <= clk_m[1];
         clk_prev_q <= clk_s;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] test_q, page_q, pwr_a_q, pwr_b_q, map_q;
   logic       wr_en;
   logic       rst_seen_q;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   assign wr_en = psel && penable && pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_q <= mcs_pkg::RST_TEST_PORT;
         page_q <= mcs_pkg::RST_PAGE;
      end else if (wr_en) begin
         if (hit(paddr, mcs_pkg::OFF_TEST_PORT))
            test_q <= pwdata[7:0] & mcs_pkg::MASK_TEST_PORT;
         if (hit(paddr, mcs_pkg::OFF_PAGE))
            page_q <= pwdata[7:0];
      end
   end

   // power gating kept across bus resets; only power-up clears it
   always_ff @(posedge pclk or negedge power_on_rst_n) begin
      if (!power_on_rst_n) begin
         pwr_a_q <= mcs_pkg::RST_PWR;
         pwr_b_q <= mcs_pkg::RST_PWR;
      end else if (wr_en) begin
         if (hit(paddr, mcs_pkg::OFF_PWR_A))
            pwr_a_q <= pwdata[7:0] & mcs_pkg::MASK_PWR_A;
         if (hit(paddr, mcs_pkg::OFF_PWR_B))
            pwr_b_q <= pwdata[7:0] & mcs_pkg::MASK_PWR_B;
      end
   end

   // defaults reloaded by a clocked step after reset, not from the port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_q      <= 8'h00;
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
         if (!rst_seen_q)
            map_q <= SPACE_MAP_DEFAULT & mcs_pkg::SPACE_MAP_KEEP;
         else if (wr_en && hit(paddr, mcs_pkg::OFF_SPACE_MAP))
            map_q <= pwdata[7:0] & mcs_pkg::MASK_SPACE_MAP;
      end
   end

   // ************************************************************
   // apb read path
   // ************************************************************
   logic [7:0] rd_byte;
   logic       mapped;

   // status and size codes assembled with unused bits forced low
   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      case (paddr)
         mcs_pkg::OFF_PRI_LOCK:  rd_byte = lock_p_s;
         mcs_pkg::OFF_SEC_LOCK:  rd_byte = {lock_s_s[4], 3'h0, lock_s_s[3:0]};
         mcs_pkg::OFF_TEST_PORT: rd_byte = test_q;
         mcs_pkg::OFF_PAGE:      rd_byte = page_q;
         mcs_pkg::OFF_PWR_A:     rd_byte = pwr_a_q;
         mcs_pkg::OFF_PWR_B:     rd_byte = pwr_b_q;
         mcs_pkg::OFF_SPACE_MAP: rd_byte = map_q;
         mcs_pkg::OFF_MEM_A:     rd_byte = {SRAM_SIZE_CODE, PRI_SIZE_CODE};
         mcs_pkg::OFF_MEM_B:     rd_byte = {2'h0, SEC_TYPE_CODE, SEC_SIZE_CODE};
         default:                mapped  = 1'b0;
      endcase
   end

   // zero-wait slave: answers in the first access cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= {24'h00_0000, rd_byte};
   end

   // ************************************************************
   // control outputs
   // ************************************************************
   logic       map_live;
   logic [7:0] arr_addr;

   assign test_port_on       = test_q[mcs_pkg::BIT_TEST_ON];
   assign page_bits          = page_q;
   assign port_f_periph_mode = map_q[mcs_pkg::BIT_PERIPH];
   assign map_live           = alt_bus_mode;

   // alternate bus mode re-sources the array address nibbles
   assign arr_addr = alt_bus_mode ? {mux_bus_upper_lines, port_f_low_pins}
                                  : addr_low_in;

   // blocked inputs held low so the array sees no toggling
   always_comb begin
      gate_out.auto_power_down = pwr_a_q[mcs_pkg::BIT_APD];
      gate_out.turbo_off       = pwr_a_q[mcs_pkg::BIT_TURBO_OFF];
      gate_out.array_clk_gate  = pwr_a_q[mcs_pkg::BIT_ARRAY_CLK] ? 1'b0 : clk_s;
      gate_out.mcell_clk_gate  = pwr_a_q[mcs_pkg::BIT_MCELL_CLK] ? 1'b0 : clk_s;
      gate_out.array_addr      = pwr_b_q[mcs_pkg::BIT_ADDR_BLOCK] ? 8'h00 : arr_addr;
      gate_out.control_in      = control_inputs & ~pwr_b_q[4:2];
      gate_out.ale_in          = ale_in & ~pwr_b_q[5];
      gate_out.high_byte_write_strobe = high_byte_write_strobe & ~pwr_b_q[6];
   end

   // wake only matters with turbo off and the clock connected
   assign array_wake = (clk_s != clk_prev_q) && pwr_a_q[mcs_pkg::BIT_TURBO_OFF]
                       && !pwr_a_q[mcs_pkg::BIT_ARRAY_CLK];

   // ************************************************************
   // memory selects
   // ************************************************************
   logic allow_pri, allow_sec, allow_sram;

   // strobe permissions bypassed outside alternate bus mode
   always_comb begin
      allow_pri  = 1'b1;
      allow_sec  = 1'b1;
      allow_sram = 1'b1;
      if (map_live) begin
         allow_pri  = (program_fetch_strobe && map_q[mcs_pkg::BIT_FETCH_PRI])
                   || (read_strobe && map_q[mcs_pkg::BIT_READ_PRI]);
         allow_sec  = (program_fetch_strobe && map_q[mcs_pkg::BIT_FETCH_SEC])
                   || (read_strobe && map_q[mcs_pkg::BIT_READ_SEC]);
         allow_sram = !program_fetch_strobe || map_q[mcs_pkg::BIT_FETCH_SRAM];
      end
   end

   // one-hot sector decode; registered so selects come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_sector_selects   <= 8'h00;
         secondary_sector_selects <= 4'h0;
         sram_select              <= 1'b0;
      end else begin
         primary_sector_selects   <= (region_hit[2] && allow_pri)
                                     ? (8'h01 << sector_index) : 8'h00;
         secondary_sector_selects <= (region_hit[1] && allow_sec)
                                     ? (4'h1 << sector_index[1:0]) : 4'h0;
         sram_select              <= region_hit[0] && allow_sram;
      end
   end

endmodule
`default_nettype wire

// ---- test/mcs_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ************
// bus-side partner: pins move just after an edge
// ************
module mcs_far_model (
   input  wire logic        pclk,                   // bus clock
   input  wire logic [47:0] stim,                   // pin pattern
   output logic [7:0]       addr_low_in,            // address lines
   output logic [3:0]       port_f_low_pins,        // alternate low
   output logic [3:0]       mux_bus_upper_lines,    // alternate high
   output logic [2:0]       control_inputs,         // control inputs
   output logic             ale_in,                 // latch strobe
   output logic             high_byte_write_strobe, // high byte write
   output logic [2:0]       region_hit,             // pri, sec, sram
   output logic [2:0]       sector_index,           // sector number
   output logic             program_fetch_strobe,   // fetch cycle
   output logic             read_strobe,            // read cycle
   output logic             security_set_in,        // security flag
   output logic [3:0]       secondary_lock_in,      // boot locks
   output logic [7:0]       primary_lock_in,        // main locks
   output logic             external_clock_input    // array clock pin
);
   // whole pattern lands at once, so no pin is left mid-change
   always_ff @(posedge pclk) begin
      {external_clock_input, primary_lock_in, secondary_lock_in, security_set_in, read_strobe,
       program_fetch_strobe, sector_index, region_hit, high_byte_write_strobe, ale_in,
       control_inputs, mux_bus_upper_lines, port_f_low_pins, addr_low_in} <= stim[42:0];
   end
endmodule
`default_nettype wire

// ---- test/mcs_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module mcs_props (
   input wire logic               pclk,                   // bus clock
   input wire logic               presetn,                // bus reset, low
   input wire logic               power_on_rst_n,         // power-up reset, low
   input wire logic               psel,                   // apb select
   input wire logic               penable,                // apb access
   input wire logic               pwrite,                 // apb write
   input wire logic [11:0]        paddr,                  // apb address
   input wire logic [31:0]        pwdata,                 // apb write data
   input wire logic [31:0]        prdata,                 // apb read data
   input wire logic [7:0]         page_bits,              // page outputs
   input wire logic               test_port_on,           // test port enable
   input wire logic               port_f_periph_mode,     // port F mode
   input wire mcs_pkg::mcs_gate_t gate_out,               // gated array inputs
   input wire logic               alt_bus_mode,           // 16-bit mode
   input wire logic [7:0]         addr_low_in,            // address lines
   input wire logic [3:0]         port_f_low_pins,        // alternate low address
   input wire logic [3:0]         mux_bus_upper_lines,    // alternate high address
   input wire logic [2:0]         control_inputs,         // control inputs
   input wire logic               ale_in,                 // latch strobe
   input wire logic               high_byte_write_strobe, // high byte write
   input wire logic               external_clock_input,   // array clock pin
   input wire logic               array_wake              // clock change wake pulse
);
   logic       wr;
   logic [2:0] up_q;
   logic [7:0] pa_q;
   logic [7:0] pb_q;
   assign wr = psel && penable && pwrite;
   // shadow of the gating regs; bus reset must not touch them, so only power-up clears
   always_ff @(posedge pclk or negedge power_on_rst_n) begin
      if (!power_on_rst_n) begin
         pa_q <= 8'h00;
         pb_q <= 8'h00;
      end else if (wr && paddr == mcs_pkg::OFF_PWR_A) begin
         pa_q <= pwdata[7:0] & 8'h3A;
      end else if (wr && paddr == mcs_pkg::OFF_PWR_B) begin
         pb_q <= pwdata[7:0] & 8'h7D;
      end
   end
   // pin history is only meaningful once the synchroniser stages refilled after a bus reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_q <= 3'h0;
      end else if (up_q != 3'h4) begin
         up_q <= up_q + 3'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_page_write: assert property (wr && paddr == mcs_pkg::OFF_PAGE |=> page_bits == $past(pwdata[7:0]))
      else $error("page bits miss write");
   a_test_write: assert property (wr && paddr == mcs_pkg::OFF_TEST_PORT |=> test_port_on == $past(pwdata[0]))
      else $error("test port enable miss write");
   a_periph_write: assert property (wr && paddr == mcs_pkg::OFF_SPACE_MAP |=> port_f_periph_mode == $past(pwdata[7]))
      else $error("peripheral mode miss write");
   a_addr_block: assert property (pb_q[0] |-> gate_out.array_addr == 8'h00)
      else $error("address not blocked");
   a_addr_route: assert property (!pb_q[0] |-> gate_out.array_addr ==
      (alt_bus_mode ? {mux_bus_upper_lines, port_f_low_pins} : addr_low_in)) else $error("array address wrong");
   a_ctl_gate: assert property ({gate_out.control_in, gate_out.ale_in, gate_out.high_byte_write_strobe} ==
      ({control_inputs, ale_in, high_byte_write_strobe} & ~{pb_q[4:2], pb_q[5], pb_q[6]})) else $error("gated input");
   a_pwr_follow: assert property ({gate_out.auto_power_down, gate_out.turbo_off} == {pa_q[1], pa_q[3]})
      else $error("power gating bits wrong");
   a_upper_zero: assert property (prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_clk_gate: assert property (up_q == 3'h4 |->
      gate_out.array_clk_gate == (!pa_q[4] && $past(external_clock_input, 3))
      && gate_out.mcell_clk_gate == (!pa_q[5] && $past(external_clock_input, 3))) else $error("clock gating wrong");
   a_wake_pulse: assert property (up_q == 3'h4 |-> array_wake ==
      (pa_q[3] && !pa_q[4] && ($past(external_clock_input, 3) != $past(external_clock_input, 4))))
      else $error("array wake pulse wrong");
   c_wake: cover property (array_wake);
   c_page_write: cover property (wr && paddr == mcs_pkg::OFF_PAGE);
   c_alt_route: cover property (alt_bus_mode && !pb_q[0]);
   c_addr_block: cover property (pb_q[0]);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic pclk, presetn, power_on_rst_n, psel, penable, pwrite, alt_bus_mode, pready, pslverr, err;
   logic test_port_on, array_wake, port_f_periph_mode, sram_select, external_clock_input, security_set_in;
   logic ale_in, high_byte_write_strobe, program_fetch_strobe, read_strobe;
   logic [2:0] control_inputs, region_hit, sector_index;
   logic [3:0] port_f_low_pins, mux_bus_upper_lines, secondary_lock_in, secondary_sector_selects;
   logic [7:0] addr_low_in, primary_lock_in, page_bits, primary_sector_selects;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, sel_seen;
   logic [47:0] stim;
   logic [7:0] mdl [9];
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   mcs_pkg::mcs_gate_t gate_out;
   localparam logic [7:0] WM [9] = '{8'h00, 8'h00, 8'h01, 8'hFF, 8'h3A, 8'h7D, 8'h9F, 8'h00, 8'h00};
   assign sel_seen = {19'h0, primary_sector_selects, secondary_sector_selects, sram_select};
   mcs_regs u_dut (.pclk, .presetn, .power_on_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .primary_lock_in, .secondary_lock_in, .security_set_in, .alt_bus_mode,
      .external_clock_input, .addr_low_in, .port_f_low_pins, .mux_bus_upper_lines, .control_inputs, .ale_in,
      .high_byte_write_strobe, .region_hit, .sector_index, .program_fetch_strobe, .read_strobe, .test_port_on,
      .page_bits, .gate_out, .array_wake, .port_f_periph_mode, .primary_sector_selects,
      .secondary_sector_selects, .sram_select);
   mcs_far_model u_far (.pclk, .stim, .addr_low_in, .port_f_low_pins, .mux_bus_upper_lines, .control_inputs,
      .ale_in, .high_byte_write_strobe, .region_hit, .sector_index, .program_fetch_strobe, .read_strobe,
      .security_set_in, .secondary_lock_in, .primary_lock_in, .external_clock_input);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one transfer; request held until pready is seen at an edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed; pready or the hang guard ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // new pin pattern; four cycles cover the status synchronisers
   task automatic new_stim();
      logic [31:0] a;
      a = rnd();
      stim <= {a[15:0], rnd()};
      alt_bus_mode <= a[16];
      repeat (4) @(posedge pclk);
   endtask
   // every word plus the first unmapped one
   task automatic check_all();
      logic [7:0] e;
      for (int i = 0; i < 10; i++) begin
         apb(12'(i * 4), 1'b0, 32'h0);
         case (i)
            0: e = stim[41:34];
            1: e = {stim[29], 3'b000, stim[33:30]};
            7: e = 8'h34;
            8: e = 8'h02;
            9: e = 8'h00;
            default: e = mdl[i];
         endcase
         check("prdata", rd, {24'h0, e});
         check("pslverr", {31'h0, err}, {31'h0, i == 9});
      end
      check("outputs", {22'h0, page_bits, test_port_on, port_f_periph_mode}, {22'h0, mdl[3], mdl[2][0], mdl[6][7]});
   endtask
   // random writes, read-only and unmapped words too
   task automatic write_all();
      logic [31:0] d;
      for (int i = 0; i < 10; i++) begin
         d = rnd();
         apb(12'(i * 4), 1'b1, d);
         if (i < 9) mdl[i] = d[7:0] & WM[i];
      end
   endtask
   // each region under fetch, then read; every sector seen across the two halves
   task automatic sel_sweep();
      logic [47:0] s;
      logic [7:0] m, ep;
      logic [3:0] es;
      logic ap, asec, am, f;
      m = mdl[6];
      for (int k = 0; k < 24; k++) begin
         s = stim;
         s[23:21] = 3'b001 << (k % 3);
         s[26:24] = 3'(k);
         s[28:27] = (k < 12) ? 2'b01 : 2'b10;
         stim <= s;
         repeat (3) @(posedge pclk);
         f = s[27];
         ap = !alt_bus_mode || (f ? m[2] : m[4]);
         asec = !alt_bus_mode || (f ? m[1] : m[3]);
         am = !alt_bus_mode || !f || m[0];
         ep = (s[23] && ap) ? (8'h01 << s[26:24]) : 8'h00;
         es = (s[22] && asec) ? (4'h1 << s[25:24]) : 4'h0;
         check("selects", sel_seen, {19'h0, ep, es, s[21] && am});
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      seed = 32'h0000D26B;
      {presetn, power_on_rst_n, psel, penable, pwrite, alt_bus_mode} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      stim = 48'h0;
      for (int i = 0; i < 9; i++) mdl[i] = 8'h00;
      mdl[6] = 8'h1E;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      power_on_rst_n <= 1'b1;
      repeat (2) @(posedge pclk);
      new_stim();
      check_all();
      repeat (3) begin
         write_all();
         new_stim();
         check_all();
      end
      alt_bus_mode <= 1'b0;
      sel_sweep();
      alt_bus_mode <= 1'b1;
      repeat (2) begin
         apb(mcs_pkg::OFF_SPACE_MAP, 1'b1, rnd());
         mdl[6] = pwdata[7:0] & WM[6];
         sel_sweep();
      end
      apb(mcs_pkg::OFF_SPACE_MAP, 1'b1, 32'hFFFFFFFF);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      mdl[2] = 8'h00;
      mdl[3] = 8'h00;
      mdl[6] = 8'h1E;
      check_all();
      test_done();
   end
endmodule
bind mcs_regs mcs_props u_props (.pclk, .presetn, .power_on_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .page_bits, .test_port_on, .port_f_periph_mode, .gate_out, .alt_bus_mode, .addr_low_in,
   .port_f_low_pins, .mux_bus_upper_lines, .control_inputs, .ale_in, .high_byte_write_strobe,
   .external_clock_input, .array_wake);
`default_nettype wire
